// ===== common/phy_mgmt_defs.vh
// constants shared by the phy management access block and its helpers
`ifndef PHY_MGMT_DEFS_VH
`define PHY_MGMT_DEFS_VH

// ****************************************
// register map
// ****************************************
`define OFF_DATA_HOLDER     8'ha4
`define OFF_ACCESS_CTRL     8'ha8
`define FLD_PHY_HI          15
`define FLD_PHY_LO          11
`define FLD_REG_HI          10
`define FLD_REG_LO          6
`define FLD_WNR             1
`define FLD_BUSY            0
`define DATA_HI             15
`define RESET_ADDR5         5'h00
`define RESET_DATA16        16'h0000
`define ZERO_WORD           32'h00000000

// ****************************************
// port 0 management modes
// ****************************************
`define MODE_MAC_SMI        3'h0
`define MODE_MAC_SMI_INIT   3'h1
`define MODE_PHY_SMI        3'h2
`define MODE_PHY_SMI_INIT   3'h3
`define MODE_MAC_I2C        3'h4
`define MODE_PHY_I2C        3'h5

// ****************************************
// management clock timing
// ****************************************
`define CLK_PERIOD_NS       5
`define MDC_PERIOD_NS       400
`define OUT_DELAY_NS        120
`define SAMPLE_LEAD_NS      40
`define MDC_PERIOD_CYC      (`MDC_PERIOD_NS / `CLK_PERIOD_NS)
`define MDC_HALF_CYC        (`MDC_PERIOD_CYC / 2)
`define MDC_CHANGE_CYC      (`MDC_HALF_CYC + `OUT_DELAY_NS / `CLK_PERIOD_NS)
`define MDC_SAMPLE_CYC      (`MDC_HALF_CYC - `SAMPLE_LEAD_NS / `CLK_PERIOD_NS)
`define MDC_CNT_W           7

// ****************************************
// frame layout
// ****************************************
`define FRAME_PREAMBLE      32'hffffffff
`define FRAME_START         2'b01
`define FRAME_OP_RD         2'b10
`define FRAME_OP_WR         2'b01
`define FRAME_TA_WR         2'b10
`define FRAME_TA_RD         2'b11
`define FRAME_LAST_BIT      6'd63
`define FRAME_TA_BIT        6'd46
`define FRAME_DATA_BIT      6'd48

`endif

// ===== verilog/pin_sync.v
// two flip-flop synchroniser for a group of asynchronous inputs
`timescale 1ns/1ps
`default_nettype none
module pin_sync
#(
    parameter WIDTH = 4
)
(
    input  wire             clk,
    input  wire             rst,
    input  wire [WIDTH-1:0] din,
    output wire [WIDTH-1:0] dout
);
    genvar i;
    generate
        for (i = 0; i < WIDTH; i = i + 1)
        begin : g_bit
            reg meta;
            reg stable;
            // idle management lines float high, so reset to one
            always @(posedge clk or posedge rst)
            begin
                if (rst)
                begin
                    meta   <= 1'b1;
                    stable <= 1'b1;
                end
                else
                begin
                    meta   <= din[i];
                    stable <= meta;
                end
            end
            assign dout[i] = stable;
        end
    endgenerate
endmodule // pin_sync
`default_nettype wire

// ===== verilog/mdc_divider.v
// management clock divider with change and sample strobes
`timescale 1ns/1ps
`default_nettype none
`include "phy_mgmt_defs.vh"
module mdc_divider
(
    input  wire clk,
    input  wire rst,
    input  wire run,
    output reg  mdc,
    output reg  change,
    output reg  sample
);
    reg [`MDC_CNT_W-1:0] cnt;

    // ****************************************
    // divide the system clock down to the management clock
    // ****************************************
    // 2.5 mhz divider
    always @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            cnt    <= {`MDC_CNT_W{1'b0}};
            mdc    <= 1'b0;
            change <= 1'b0;
            sample <= 1'b0;
        end
        else if (!run)
        begin
            cnt    <= {`MDC_CNT_W{1'b0}};
            mdc    <= 1'b0;
            change <= 1'b0;
            sample <= 1'b0;
        end
        else
        begin
            if (cnt == `MDC_PERIOD_CYC - 1)
                cnt <= {`MDC_CNT_W{1'b0}};
            else
                cnt <= cnt + 1'b1;
            mdc    <= (cnt >= `MDC_HALF_CYC - 1) && (cnt != `MDC_PERIOD_CYC - 1);
            change <= (cnt == `MDC_CHANGE_CYC - 1);
            sample <= (cnt == `MDC_SAMPLE_CYC - 1);
        end
    end
endmodule // mdc_divider
`default_nettype wire

// ===== verilog/phy_mgmt_access_and_mux.v
// phy management master registers, frame engine and port 0 management multiplexer
`timescale 1ns/1ps
`default_nettype none
`include "phy_mgmt_defs.vh"
module phy_mgmt_access_and_mux
(
    input  wire        MCLK,
    input  wire        RST,
    // host register port (serial slave or i2c slave side)
    input  wire        HOST_WR,
    input  wire        HOST_RD,
    input  wire [7:0]  HOST_ADDR,
    input  wire [31:0] HOST_WDATA,
    output reg  [31:0] HOST_RDATA,
    output reg         HOST_RVALID,
    // eeprom loader write-only port
    input  wire        EE_WR,
    input  wire [7:0]  EE_ADDR,
    input  wire [31:0] EE_WDATA,
    output reg         EE_BUSY,
    // mode selection
    input  wire [2:0]  MGMT_MODE,
    // internal phys a and b
    output reg         PHY_MDC,
    output reg         PHY_MDIO_OUT,
    input  wire        PHY_MDIO_IN,
    // serial management slave block
    output reg         SLV_MDC,
    output reg         SLV_MDIO_OUT,
    input  wire        SLV_MDIO_IN,
    // port 0 mii management pins
    input  wire        P0_MDC_IN,
    output reg         P0_MDC_OUT,
    output reg         P0_MDC_OE_N,
    input  wire        P0_MDIO_IN,
    output reg         P0_MDIO_OUT,
    output reg         P0_MDIO_OE_N
);
    // ****************************************
    // declarations
    // ****************************************
    localparam ST_IDLE = 3'b001;
    localparam ST_RUN  = 3'b010;
    localparam ST_DONE = 3'b100;

    reg  [2:0]  state;
    reg  [4:0]  target_phy_select;
    reg  [4:0]  phy_reg_index;
    reg         write_not_read_select;
    reg         access_in_progress_flag;
    reg  [15:0] host_data;
    reg  [15:0] phy_data;
    reg  [15:0] capture;
    reg  [63:0] shifter;
    reg  [5:0]  bit_idx;
    reg         m_out;
    reg         m_drive;

    wire [3:0]  synced;
    wire        ext_mdc;
    wire        ext_mdio;
    wire        phy_in;
    wire        slv_in;
    wire        m_mdc;
    wire        m_change;
    wire        m_sample;
    wire        m_line;
    wire        m_read_in;
    wire        ext_read_back;

    reg         acc_wr;
    reg  [31:0] acc_val;
    reg         dat_wr;
    reg  [15:0] dat_val;
    reg         host_ok;
    reg  [63:0] next_shifter;

    // ****************************************
    // mode decoding
    // ****************************************
    function internal_owns_phys;
        input [2:0] mode;
        begin
            // init modes and i2c modes use internal master
            internal_owns_phys = (mode == `MODE_MAC_SMI_INIT) || (mode == `MODE_PHY_SMI_INIT) ||
                                 (mode == `MODE_MAC_I2C) || (mode == `MODE_PHY_I2C);
        end
    endfunction

    function init_mode;
        input [2:0] mode;
        begin
            init_mode = (mode == `MODE_MAC_SMI_INIT) || (mode == `MODE_PHY_SMI_INIT);
        end
    endfunction

    function smi_mode;
        input [2:0] mode;
        begin
            smi_mode = (mode == `MODE_MAC_SMI) || (mode == `MODE_MAC_SMI_INIT) ||
                       (mode == `MODE_PHY_SMI) || (mode == `MODE_PHY_SMI_INIT);
        end
    endfunction

    // ****************************************
    // input synchronisers and clock divider
    // ****************************************
    pin_sync #(.WIDTH(4)) u_sync
    (
        .clk  (MCLK),
        .rst  (RST),
        .din  ({SLV_MDIO_IN, PHY_MDIO_IN, P0_MDIO_IN, P0_MDC_IN}),
        .dout (synced)
    );
    assign ext_mdc  = synced[0];
    assign ext_mdio = synced[1];
    assign phy_in   = synced[2];
    assign slv_in   = synced[3];

    mdc_divider u_div
    (
        .clk    (MCLK),
        .rst    (RST),
        .run    (state == ST_RUN),
        .mdc    (m_mdc),
        .change (m_change),
        .sample (m_sample)
    );

    // ****************************************
    // register write arbitration
    // ****************************************
    always @*
    begin
        acc_wr  = 1'b0;
        acc_val = `ZERO_WORD;
        dat_wr  = 1'b0;
        dat_val = `RESET_DATA16;
        // host port is shut off during device initialisation
        host_ok = !init_mode(MGMT_MODE);
        // loader only writes; it takes priority over the host
        if (EE_WR)
        begin
            acc_wr  = (EE_ADDR == `OFF_ACCESS_CTRL);
            acc_val = EE_WDATA;
            dat_wr  = (EE_ADDR == `OFF_DATA_HOLDER);
            dat_val = EE_WDATA[`DATA_HI:0];
        end
        else if (HOST_WR && host_ok)
        begin
            acc_wr  = (HOST_ADDR == `OFF_ACCESS_CTRL);
            acc_val = HOST_WDATA;
            dat_wr  = (HOST_ADDR == `OFF_DATA_HOLDER);
            dat_val = HOST_WDATA[`DATA_HI:0];
        end
    end

    // ****************************************
    // frame image
    // ****************************************
    // preamble, start, opcode, address, index, turnaround, data
    always @*
    begin
        next_shifter = {`FRAME_PREAMBLE, `FRAME_START,
                        acc_val[`FLD_WNR] ? `FRAME_OP_WR : `FRAME_OP_RD,
                        acc_val[`FLD_PHY_HI:`FLD_PHY_LO], acc_val[`FLD_REG_HI:`FLD_REG_LO],
                        acc_val[`FLD_WNR] ? `FRAME_TA_WR : `FRAME_TA_RD,
                        acc_val[`FLD_WNR] ? host_data : 16'hffff};
    end

    // ****************************************
    // access control, data holder and frame engine
    // ****************************************
    always @(posedge MCLK or posedge RST)
    begin
        if (RST)
        begin
            state                   <= ST_IDLE;
            target_phy_select       <= `RESET_ADDR5;
            phy_reg_index           <= `RESET_ADDR5;
            write_not_read_select   <= 1'b0;
            access_in_progress_flag <= 1'b0;
            host_data               <= `RESET_DATA16;
            phy_data                <= `RESET_DATA16;
            capture                 <= `RESET_DATA16;
            shifter                 <= 64'h0;
            bit_idx                 <= 6'd0;
            m_out                   <= 1'b1;
            m_drive                 <= 1'b0;
            EE_BUSY                 <= 1'b0;
        end
        else
        begin
            // data held steady while busy, so a running write keeps its value
            if (dat_wr && !access_in_progress_flag)
                host_data <= dat_val;
            case (state)
                ST_IDLE:
                begin
                    if (acc_wr && !access_in_progress_flag)
                    begin
                        target_phy_select       <= acc_val[`FLD_PHY_HI:`FLD_PHY_LO];
                        phy_reg_index           <= acc_val[`FLD_REG_HI:`FLD_REG_LO];
                        write_not_read_select   <= acc_val[`FLD_WNR];
                        access_in_progress_flag <= 1'b1;
                        EE_BUSY                 <= 1'b1;
                        shifter                 <= next_shifter;
                        bit_idx                 <= 6'd0;
                        m_out                   <= 1'b1;
                        m_drive                 <= 1'b1;
                        state                   <= ST_RUN;
                    end
                end
                ST_RUN:
                begin
                    if (m_sample && !write_not_read_select && bit_idx >= `FRAME_DATA_BIT)
                        capture <= {capture[14:0], m_read_in};
                    if (m_change)
                    begin
                        if (bit_idx == `FRAME_LAST_BIT)
                        begin
                            m_drive <= 1'b0;
                            m_out   <= 1'b1;
                            state   <= ST_DONE;
                        end
                        else
                        begin
                            bit_idx <= bit_idx + 1'b1;
                            shifter <= {shifter[62:0], 1'b1};
                            m_out   <= shifter[62];
                            // read releases the line from turnaround on
                            if (!write_not_read_select && bit_idx + 1'b1 == `FRAME_TA_BIT)
                                m_drive <= 1'b0;
                        end
                    end
                end
                ST_DONE:
                begin
                    // read data lands with busy clearing
                    if (!write_not_read_select)
                        phy_data <= capture;
                    access_in_progress_flag <= 1'b0;
                    // loader sees busy drop in hardware
                    EE_BUSY                 <= 1'b0;
                    state                   <= ST_IDLE;
                end
                default:
                begin
                    state <= ST_IDLE;
                end
            endcase
        end
    end

    // ****************************************
    // host read port
    // ****************************************
    always @(posedge MCLK or posedge RST)
    begin
        if (RST)
        begin
            HOST_RDATA  <= `ZERO_WORD;
            HOST_RVALID <= 1'b0;
        end
        else
        begin
            HOST_RVALID <= HOST_RD && host_ok;
            HOST_RDATA  <= `ZERO_WORD;
            if (HOST_RD && host_ok)
            begin
                if (HOST_ADDR == `OFF_ACCESS_CTRL)
                    HOST_RDATA <= {16'h0000, target_phy_select, phy_reg_index, 4'h0,
                                   write_not_read_select, access_in_progress_flag};
                // phy value on read direction, host value on write
                else if (HOST_ADDR == `OFF_DATA_HOLDER)
                    HOST_RDATA <= {16'h0000, write_not_read_select ? host_data : phy_data};
            end
        end
    end

    // ****************************************
    // management multiplexer
    // ****************************************
    assign m_line        = m_drive ? m_out : 1'b1;
    // read data returned to the internal master
    assign m_read_in     = (MGMT_MODE == `MODE_MAC_I2C) ? (phy_in & ext_mdio) : phy_in;
    // only the slave being addressed pulls low, so and-ing gives its bit
    assign ext_read_back = internal_owns_phys(MGMT_MODE) ? slv_in : (slv_in & phy_in);

    always @(posedge MCLK or posedge RST)
    begin
        if (RST)
        begin
            PHY_MDC      <= 1'b0;
            PHY_MDIO_OUT <= 1'b1;
            SLV_MDC      <= 1'b0;
            SLV_MDIO_OUT <= 1'b1;
            P0_MDC_OUT   <= 1'b0;
            P0_MDC_OE_N  <= 1'b1;
            P0_MDIO_OUT  <= 1'b0;
            P0_MDIO_OE_N <= 1'b1;
        end
        else
        begin
            if (internal_owns_phys(MGMT_MODE))
            begin
                PHY_MDC      <= m_mdc;
                PHY_MDIO_OUT <= m_line;
            end
            else
            begin
                // internal frames stay off the phys
                PHY_MDC      <= ext_mdc;
                PHY_MDIO_OUT <= ext_mdio;
            end
            // serial modes hand the serial slave to the pins
            if (smi_mode(MGMT_MODE))
            begin
                SLV_MDC      <= ext_mdc;
                SLV_MDIO_OUT <= ext_mdio;
                P0_MDC_OUT   <= 1'b0;
                P0_MDC_OE_N  <= 1'b1;
                // open drain return on the pins
                P0_MDIO_OE_N <= ext_read_back;
            end
            else if (MGMT_MODE == `MODE_MAC_I2C)
            begin
                SLV_MDC      <= 1'b0;
                SLV_MDIO_OUT <= 1'b1;
                P0_MDC_OUT   <= m_mdc;
                P0_MDC_OE_N  <= 1'b0;
                P0_MDIO_OE_N <= m_line;
            end
            else
            begin
                SLV_MDC      <= 1'b0;
                SLV_MDIO_OUT <= 1'b1;
                P0_MDC_OUT   <= 1'b0;
                P0_MDC_OE_N  <= 1'b1;
                P0_MDIO_OE_N <= 1'b1;
            end
            P0_MDIO_OUT <= 1'b0;
        end
    end
endmodule // phy_mgmt_access_and_mux
`default_nettype wire

// ===== verification/phy_mgmt_checker_assertions.sv
// concurrent checks on the phy management block ports
`timescale 1ns/1ps
`default_nettype none
module phy_mgmt_checker
(
    input wire logic       MCLK,
    input wire logic       RST,
    input wire logic       HOST_WR,
    input wire logic       HOST_RD,
    input wire logic [7:0] HOST_ADDR,
    input wire logic       HOST_RVALID,
    input wire logic       EE_WR,
    input wire logic [7:0] EE_ADDR,
    input wire logic       EE_BUSY,
    input wire logic [2:0] MGMT_MODE,
    input wire logic       PHY_MDC,
    input wire logic       SLV_MDC,
    input wire logic       SLV_MDIO_IN,
    input wire logic       P0_MDC_IN,
    input wire logic       P0_MDIO_OE_N
);
    default clocking @(posedge MCLK); endclocking
    default disable iff (RST);
    logic [15:0] busy_len;
    logic [15:0] gap;
    logic        mdc_q;
    wire         lock = MGMT_MODE == 3'h1 || MGMT_MODE == 3'h3;
    wire         own  = lock || MGMT_MODE == 3'h4 || MGMT_MODE == 3'h5;
    wire         go   = (HOST_WR && !lock && HOST_ADDR == 8'ha8) || (EE_WR && EE_ADDR == 8'ha8);
    // gap stays zero until the first clock rise of a frame, so idle time is never measured
    always_ff @(posedge MCLK or posedge RST)
    begin
        if (RST)
        begin
            busy_len <= 16'h0000;
            gap      <= 16'h0000;
            mdc_q    <= 1'b0;
        end
        else
        begin
            busy_len <= EE_BUSY ? busy_len + 16'h0001 : 16'h0000;
            gap      <= !EE_BUSY ? 16'h0000 : (PHY_MDC && !mdc_q) ? 16'h0001 :
                        (gap == 16'h0000) ? gap : gap + 16'h0001;
            mdc_q    <= PHY_MDC;
        end
    end
    property p_busy_set; go && !EE_BUSY |-> ##[1:2] EE_BUSY; endproperty
    a_busy_set: assert property (p_busy_set) else $error("busy not set by access write");
    property p_busy_len; $fell(EE_BUSY) |-> busy_len >= 16'd5100 && busy_len <= 16'd5140; endproperty
    a_busy_len: assert property (p_busy_len) else $error("busy span wrong");
    property p_mdc_period; $rose(PHY_MDC) && own && gap != 16'h0000 |-> gap == 16'd80; endproperty
    a_mdc_period: assert property (p_mdc_period) else $error("management clock period wrong");
    property p_pin_mdc; MGMT_MODE == 3'h0 && $rose(P0_MDC_IN) |-> ##[1:4] PHY_MDC; endproperty
    a_pin_mdc: assert property (p_pin_mdc) else $error("pin clock not passed to phys");
    property p_slv_mdc; (MGMT_MODE == 3'h0 || lock) && $rose(P0_MDC_IN) |-> ##[1:4] SLV_MDC; endproperty
    a_slv_mdc: assert property (p_slv_mdc) else $error("pin clock not passed to slave");
    property p_pin_low; (MGMT_MODE == 3'h0 && !P0_MDC_IN) [*6] |-> !PHY_MDC; endproperty
    a_pin_low: assert property (p_pin_low) else $error("internal clock reached phys");
    property p_mdio_oe; (MGMT_MODE == 3'h0 && !SLV_MDIO_IN) [*4] |-> !P0_MDIO_OE_N; endproperty
    a_mdio_oe: assert property (p_mdio_oe) else $error("pin data enable wrong");
    property p_lock; lock && HOST_RD |=> !HOST_RVALID; endproperty
    a_lock: assert property (p_lock) else $error("host answered in init mode");
    property p_rvalid; !lock && HOST_RD |=> HOST_RVALID; endproperty
    a_rvalid: assert property (p_rvalid) else $error("host read not answered");
endmodule // phy_mgmt_checker
`default_nettype wire

// ===== verification/phy_mgmt_phy_model.sv
// behavioural internal phy that answers management frames
`timescale 1ns/1ps
`default_nettype none
module phy_mgmt_phy_model
(
    input  wire logic        mdc,
    input  wire logic        mdio_in,
    output var  logic        mdio_out,
    output var  logic [15:0] last_word,
    output var  logic [11:0] last_head
);
    logic [33:0] bits;
    logic [15:0] mem [0:31];
    int          pos;
    initial
    begin
        bits = 34'h000000000;
        pos = 0;
        mdio_out = 1'b1;
        last_word = 16'h0000;
        last_head = 12'h000;
        for (int i = 0; i < 32; i++)
            mem[i] = 16'hc35a ^ 16'(i);
    end
    always @(posedge mdc)
    begin
        if (pos == 46)
            last_head = bits[11:0];
        if (pos == 63 && last_head[11:10] == 2'b01)
        begin
            last_word = {bits[14:0], mdio_in};
            mem[last_head[4:0]] = last_word;
        end
        bits = {bits[32:0], mdio_in};
        if (pos != 0)
            pos = (pos == 63) ? 0 : pos + 1;
        else if (bits == 34'h3fffffffd)
            pos = 34;
        // turnaround low, then data; released line sits at the pull-up level
        if (last_head[11:10] == 2'b10 && pos >= 47)
            mdio_out = (pos == 47) ? 1'b0 : mem[last_head[4:0]][63 - pos];
        else
            mdio_out = 1'b1;
    end
endmodule // phy_mgmt_phy_model
`default_nettype wire

// ===== verification/tb.sv
// self-checking bench for the phy management block
`timescale 1ns/1ps
`default_nettype none
module tb;
    logic        MCLK = 1'b0;
    logic        RST = 1'b1;
    logic        HOST_WR = 1'b0;
    logic        HOST_RD = 1'b0;
    logic [7:0]  HOST_ADDR = 8'h00;
    logic [31:0] HOST_WDATA = 32'h00000000;
    logic [31:0] HOST_RDATA;
    logic        HOST_RVALID;
    logic        EE_WR = 1'b0;
    logic        EE_BUSY;
    logic [2:0]  MGMT_MODE = 3'h5;
    logic        PHY_MDC;
    logic        PHY_MDIO_OUT;
    logic        PHY_MDIO_IN;
    logic        SLV_MDC;
    logic        SLV_MDIO_IN = 1'b1;
    logic        P0_MDC_IN = 1'b0;
    logic        P0_MDIO_OE_N;
    logic        P0_MDIO_IN = 1'b1;
    logic        SLV_MDIO_OUT;
    logic        P0_MDC_OUT;
    logic        P0_MDC_OE_N;
    logic        P0_MDIO_OUT;
    logic [15:0] word;
    logic [11:0] head;
    logic [31:0] rdata;
    logic        rvalid;
    int          fail_count = 0;
    int          samples_checked = 0;
    int          high_cnt;
    always #2.5 MCLK = ~MCLK;
    phy_mgmt_access_and_mux i_dut
    (
        .MCLK(MCLK), .RST(RST), .HOST_WR(HOST_WR), .HOST_RD(HOST_RD), .HOST_ADDR(HOST_ADDR),
        .HOST_WDATA(HOST_WDATA), .HOST_RDATA(HOST_RDATA), .HOST_RVALID(HOST_RVALID), .EE_WR(EE_WR),
        .EE_ADDR(HOST_ADDR), .EE_WDATA(HOST_WDATA), .EE_BUSY(EE_BUSY), .MGMT_MODE(MGMT_MODE),
        .PHY_MDC(PHY_MDC), .PHY_MDIO_OUT(PHY_MDIO_OUT), .PHY_MDIO_IN(PHY_MDIO_IN), .SLV_MDC(SLV_MDC),
        .SLV_MDIO_OUT(SLV_MDIO_OUT), .SLV_MDIO_IN(SLV_MDIO_IN), .P0_MDC_IN(P0_MDC_IN), .P0_MDC_OUT(P0_MDC_OUT),
        .P0_MDC_OE_N(P0_MDC_OE_N), .P0_MDIO_IN(P0_MDIO_IN), .P0_MDIO_OUT(P0_MDIO_OUT), .P0_MDIO_OE_N(P0_MDIO_OE_N)
    );
    phy_mgmt_phy_model i_phy
    (
        .mdc(PHY_MDC), .mdio_in(PHY_MDIO_OUT), .mdio_out(PHY_MDIO_IN), .last_word(word), .last_head(head)
    );
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp)
        begin
            fail_count++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge MCLK);
        #1;
    endtask
    // the loader shares address and data lines with the host port
    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic ee);
        HOST_ADDR = a;
        HOST_WDATA = d;
        HOST_WR = !ee;
        EE_WR = ee;
        cyc(1);
        HOST_WR = 1'b0;
        EE_WR = 1'b0;
        cyc(1);
    endtask
    task automatic rd(input logic [7:0] a);
        HOST_ADDR = a;
        HOST_RD = 1'b1;
        cyc(1);
        rdata = HOST_RDATA;
        rvalid = HOST_RVALID;
        HOST_RD = 1'b0;
        cyc(1);
    endtask
    task automatic rdc(input logic [7:0] a, input logic [31:0] e);
        rd(a);
        chk({31'h0, rvalid}, 32'h1);
        chk(rdata, e);
    endtask
    task automatic idle;
        for (int i = 0; i < 6000 && EE_BUSY !== 1'b0; i++)
            cyc(1);
        chk({31'h0, EE_BUSY}, 32'h0);
    endtask
    // link clock at 125 ns, unrelated to the system clock, still outside bursts
    task automatic burst(input logic phy);
        for (int i = 0; i < 16; i++)
        begin
            #12.5 P0_MDC_IN = ~P0_MDC_IN;
            #50;
            chk({31'h0, SLV_MDC}, {31'h0, P0_MDC_IN});
            if (phy)
                chk({31'h0, PHY_MDC}, {31'h0, P0_MDC_IN});
        end
        cyc(1);
    endtask
    task automatic complete_run;
        $display("checks %0d mismatches %0d", samples_checked, fail_count);
        if (fail_count == 0 && samples_checked > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    // five frames of about 5100 cycles each, with ample margin
    initial
    begin
        #300000;
        fail_count++;
        complete_run;
    end
    initial
    begin
        cyc(3);
        RST = 1'b0;
        rdc(8'ha8, 32'h0);
        rdc(8'ha4, 32'h0);
        rdc(8'h10, 32'h0);
        $display("test reset values done");
        wr(8'ha4, 32'h1234a5c3, 1'b0);
        wr(8'ha8, 32'h00009a82, 1'b0);
        rdc(8'ha8, 32'h00009a83);
        wr(8'ha8, 32'h000007c0, 1'b0);
        wr(8'ha4, 32'h00001111, 1'b0);
        idle;
        chk({20'h0, head}, {20'h0, 2'b01, 5'h13, 5'h0a});
        chk({16'h0, word}, 32'h0000a5c3);
        rdc(8'ha8, 32'h00009a82);
        rdc(8'ha4, 32'h0000a5c3);
        $display("test host write done");
        wr(8'ha8, 32'h00000fc0, 1'b0);
        idle;
        chk({20'h0, head}, {20'h0, 2'b10, 5'h01, 5'h1f});
        rdc(8'ha4, 32'h0000c345);
        $display("test host read done");
        MGMT_MODE = 3'h3;
        cyc(4);
        rd(8'ha8);
        chk({31'h0, rvalid}, 32'h0);
        MGMT_MODE = 3'h1;
        cyc(4);
        rd(8'ha8);
        chk({31'h0, rvalid}, 32'h0);
        wr(8'ha4, 32'h00000ff0, 1'b1);
        wr(8'ha8, 32'h00000002, 1'b1);
        chk({31'h0, EE_BUSY}, 32'h1);
        burst(1'b0);
        idle;
        chk({20'h0, head}, {20'h0, 2'b01, 10'h000});
        chk({16'h0, word}, 32'h00000ff0);
        $display("test loader init mode done");
        MGMT_MODE = 3'h0;
        cyc(4);
        burst(1'b1);
        wr(8'ha8, 32'h0000f802, 1'b0);
        burst(1'b1);
        rdc(8'ha8, 32'h0000f803);
        SLV_MDIO_IN = 1'b0;
        P0_MDIO_IN = 1'b0;
        cyc(5);
        chk({31'h0, P0_MDIO_OE_N}, 32'h0);
        chk({31'h0, SLV_MDIO_OUT}, 32'h0);
        chk({31'h0, PHY_MDIO_OUT}, 32'h0);
        SLV_MDIO_IN = 1'b1;
        P0_MDIO_IN = 1'b1;
        cyc(5);
        chk({31'h0, P0_MDIO_OE_N}, 32'h1);
        chk({31'h0, PHY_MDIO_OUT}, 32'h1);
        chk({30'h0, P0_MDC_OE_N, P0_MDIO_OUT}, 32'h2);
        idle;
        chk({20'h0, head}, {20'h0, 2'b01, 10'h000});
        MGMT_MODE = 3'h2;
        cyc(4);
        burst(1'b1);
        $display("test external master mode done");
        MGMT_MODE = 3'h4;
        cyc(4);
        wr(8'ha8, 32'h00000a80, 1'b0);
        high_cnt = 0;
        for (int i = 0; i < 80; i++)
        begin
            high_cnt += P0_MDC_OUT;
            cyc(1);
        end
        chk(high_cnt, 32'd40);
        // start code zero bit is on the pin by now
        cyc(2480);
        chk({30'h0, P0_MDC_OE_N, P0_MDIO_OE_N}, 32'h0);
        idle;
        chk({20'h0, head}, {20'h0, 2'b10, 5'h01, 5'h0a});
        rdc(8'ha4, 32'h0000a5c3);
        $display("test internal master on pins done");
        complete_run;
    end
endmodule // tb
bind phy_mgmt_access_and_mux phy_mgmt_checker i_chk
(
    .MCLK(MCLK), .RST(RST), .HOST_WR(HOST_WR), .HOST_RD(HOST_RD), .HOST_ADDR(HOST_ADDR),
    .HOST_RVALID(HOST_RVALID), .EE_WR(EE_WR), .EE_ADDR(EE_ADDR), .EE_BUSY(EE_BUSY), .MGMT_MODE(MGMT_MODE),
    .PHY_MDC(PHY_MDC), .SLV_MDC(SLV_MDC), .SLV_MDIO_IN(SLV_MDIO_IN), .P0_MDC_IN(P0_MDC_IN),
    .P0_MDIO_OE_N(P0_MDIO_OE_N)
);
`default_nettype wire
